// ==== supervisor_pkg.sv ====
// Shared constants for the watchdog and channel fault supervisor.
package supervisor_pkg;
	// Core clock period
	localparam int CLK_PERIOD_NS = 25;
	// Time-base tick period at the nominal capacitor setting, in ns
	localparam int TICK_PERIOD_NS = 100000;
	// Cycles per tick (100 us / 25 ns)
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	// Tick period in us; keeps the long products below the int limit
	localparam int TICK_PERIOD_US = TICK_PERIOD_NS / 1000;
	// Documented durations in their own units
	localparam int KICK_WINDOW_MS = 1620;
	localparam int TIMEOUT_LOW_MS = 202;
	localparam int REPEAT_MS = 12900;
	localparam int FILTER_US = 100;
	localparam int GOOD_HOLD_MS = 202;
	// Durations as tick counts; longest times round down, least times round up
	// Worked in us: 12.9 s expressed in ns would overflow a 32-bit int
	localparam int KICK_WINDOW_TICKS = (KICK_WINDOW_MS * 1000) / TICK_PERIOD_US;
	localparam int TIMEOUT_LOW_TICKS = (TIMEOUT_LOW_MS * 1000) / TICK_PERIOD_US;
	localparam int REPEAT_TICKS = (REPEAT_MS * 1000) / TICK_PERIOD_US;
	localparam int FILTER_TICKS = (FILTER_US * 1000 + TICK_PERIOD_NS - 1) / TICK_PERIOD_NS;
	localparam int GOOD_HOLD_TICKS = (GOOD_HOLD_MS * 1000) / TICK_PERIOD_US;
	// Tick counter width, enough for the longest interval
	localparam int TICK_CNT_W = 18;
	// Number of channels
	localparam int NUM_CHANNELS = 4;
	// Oscillator choice encodings
	localparam logic [1:0] OSC_RESISTOR = 2'h0;
	localparam logic [1:0] OSC_INTERNAL = 2'h1;
	localparam logic [1:0] OSC_EXTERNAL = 2'h2;
	// Watchdog states, one-hot
	typedef enum logic [2:0] {
		WD_WATCH = 3'h1,
		WD_TIMEOUT = 3'h2,
		WD_REPEAT = 3'h4
	} wd_state_type;
endpackage : supervisor_pkg

// ==== channel_fault_filter.sv ====
// One channel's fault output filter: assertion filter and release hold.
`timescale 1ns/1ps
module channel_fault_filter
	import supervisor_pkg::*;
#(
	parameter int FILTER_T = FILTER_TICKS,
	parameter int HOLD_T = GOOD_HOLD_TICKS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Time base
	input wire logic tick,
	// Channel status
	input wire logic chan_on,
	input wire logic in_window,
	// Fault drive, high means pull low
	output logic fault_drive
);
	initial begin
		if (FILTER_T < 1 || HOLD_T < 1 || HOLD_T >= (1 << TICK_CNT_W) ||
			FILTER_T >= (1 << TICK_CNT_W) - 1)
			$error("channel_fault_filter: bad tick counts");
	end

	logic [TICK_CNT_W-1:0] bad_cnt_ff; // Ticks spent out of window
	logic [TICK_CNT_W-1:0] good_cnt_ff; // Ticks spent good while driving low
	logic fault_ff; // Drive-low state
	logic nxt_fault;
	wire logic bad_expired;
	wire logic good_expired;

	// Strictly past the filter: the first tick may land right after the dip starts
	assign bad_expired = (bad_cnt_ff > TICK_CNT_W'(FILTER_T));
	assign good_expired = (good_cnt_ff >= TICK_CNT_W'(HOLD_T));
	// Disabled channel pulls low at once; a dip must outlast the filter
	assign nxt_fault = !chan_on ? 1'b1 :
		fault_ff ? !good_expired : bad_expired;

	// Bad-time counter, counted in ticks so it scales with the time base
	always_ff @(posedge mclk) begin
		if (!rst_b || !chan_on || in_window)
			bad_cnt_ff <= '0;
		else if (tick && !bad_expired)
			bad_cnt_ff <= bad_cnt_ff + 1'b1;
	end

	// Good-time counter; any glitch out of window restarts the hold
	always_ff @(posedge mclk) begin
		if (!rst_b || !chan_on || !in_window || !fault_ff)
			good_cnt_ff <= '0;
		else if (tick && !good_expired)
			good_cnt_ff <= good_cnt_ff + 1'b1;
	end

	// Output state; reset starts with the pin held low
	always_ff @(posedge mclk) begin
		if (!rst_b)
			fault_ff <= 1'b1;
		else
			fault_ff <= nxt_fault;
	end
	assign fault_drive = fault_ff;

	// Disabled channel pulls low on the next edge
	off_pulls_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!chan_on |=> fault_ff) else $error("disabled channel not driving low");
	// Out-of-window time short of the filter never asserts from released state
	no_early_fault_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!fault_ff && chan_on && !bad_expired |=> !fault_ff)
		else $error("fault asserted before filter time");
endmodule : channel_fault_filter

// ==== watchdog_reset_supervisor.sv ====
// Watchdog timer and four-channel fault output supervisor top level.
//
// Operation
// - Kick edge either way; timeout after 1.62 s
// - Timeout holds output low for 202 ms
// - Without kicks, repeat timeout after 12.9 s
// - Supply lockout restarts watchdog, 202 ms low
// - All timings scale with one time base
// - Timeout output is open-drain, never high
// - Channel 1 fault low if off or low
// - Channels 2-4 fault low if off or low
// - Fault timing uses the same time base
// - Fault asserts only after 100 us bad
// - Fault releases after 202 ms good
// - Channel enable inputs are active high
// - Three code bits select stage combination
// - External clock: synchronize, forced continuous mode
// - No clock: low light-load, high forced continuous
// - No clock: frequency select; high uses internal
`timescale 1ns/1ps
module watchdog_reset_supervisor
	import supervisor_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int KICK_T = KICK_WINDOW_TICKS,
	parameter int LOW_T = TIMEOUT_LOW_TICKS,
	parameter int REPEAT_T = REPEAT_TICKS,
	parameter int FILTER_T = FILTER_TICKS,
	parameter int HOLD_T = GOOD_HOLD_TICKS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Time base scale: cycles per tick, 0 selects the default
	input wire logic [15:0] timebase_setting,
	// Watchdog
	input wire logic watchdog_kick_in,
	input wire logic supply_low_lockout,
	output logic watchdog_timeout_out_n,
	output logic watchdog_timeout_oe,
	// Channel enables and status
	input wire logic channel1_on,
	input wire logic channel2_on,
	input wire logic channel3_on,
	input wire logic channel4_on,
	input wire logic [NUM_CHANNELS-1:0] output_in_window,
	// Channel fault open-drain outputs
	output logic channel1_fault_out_n,
	output logic channel1_fault_oe,
	output logic channel2_fault_out_n,
	output logic channel2_fault_oe,
	output logic channel3_fault_out_n,
	output logic channel3_fault_oe,
	output logic channel4_fault_out_n,
	output logic channel4_fault_oe,
	// Static configuration
	input wire logic stage_code_bit0,
	input wire logic stage_code_bit1,
	input wire logic stage_code_bit2,
	input wire logic mode_sync_in,
	input wire logic ext_clock_present,
	input wire logic frequency_select,
	// Derived configuration
	output logic [2:0] stage_code,
	output logic forced_continuous,
	output logic [1:0] osc_source
);
	initial begin
		if (TICK_CYC < 1 || TICK_CYC > 65535 || KICK_T < 1 || LOW_T < 1 ||
			REPEAT_T < 1 || REPEAT_T >= (1 << TICK_CNT_W) || KICK_T >= (1 << TICK_CNT_W) ||
			LOW_T >= (1 << TICK_CNT_W))
			$error("watchdog_reset_supervisor: bad timing parameters");
	end

	// Time base prescaler
	logic [15:0] pre_cnt_ff; // Cycles within the current tick
	logic tick_ff; // One-cycle tick pulse
	wire logic [15:0] tick_len;
	wire logic tick_due;

	// A zero setting falls back to the nominal capacitor value
	assign tick_len = (timebase_setting == 16'h0000) ? 16'(TICK_CYC) : timebase_setting;
	assign tick_due = (pre_cnt_ff >= tick_len - 16'h0001);

	// Every interval below counts these ticks, so all durations scale together
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pre_cnt_ff <= 16'h0000;
			tick_ff <= 1'b0;
		end else begin
			pre_cnt_ff <= tick_due ? 16'h0000 : pre_cnt_ff + 16'h0001;
			tick_ff <= tick_due;
		end
	end

	// Kick synchroniser and edge detect
	logic kick_meta_ff; // First stage, read only by the second
	logic kick_sync_ff;
	logic kick_prev_ff;
	wire logic kick_edge;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			kick_meta_ff <= 1'b0;
			kick_sync_ff <= 1'b0;
			kick_prev_ff <= 1'b0;
		end else begin
			kick_meta_ff <= watchdog_kick_in;
			kick_sync_ff <= kick_meta_ff;
			kick_prev_ff <= kick_sync_ff;
		end
	end
	// Either direction counts as a kick
	assign kick_edge = kick_sync_ff ^ kick_prev_ff;

	// Watchdog state machine
	wd_state_type wd_state_ff;
	wd_state_type nxt_wd_state;
	logic [TICK_CNT_W-1:0] wd_cnt_ff; // Ticks in the current state
	logic [TICK_CNT_W-1:0] nxt_wd_cnt;
	logic wdo_low_ff; // Drive the timeout pin low
	wire logic cnt_at_kick;
	wire logic cnt_at_low;
	wire logic cnt_at_repeat;

	assign cnt_at_kick = (wd_cnt_ff >= TICK_CNT_W'(KICK_T));
	assign cnt_at_low = (wd_cnt_ff >= TICK_CNT_W'(LOW_T));
	assign cnt_at_repeat = (wd_cnt_ff >= TICK_CNT_W'(REPEAT_T));

	// Next state; lockout overrides everything and starts a full low period
	always_comb begin
		nxt_wd_state = wd_state_ff;
		nxt_wd_cnt = tick_ff ? wd_cnt_ff + 1'b1 : wd_cnt_ff;
		if (supply_low_lockout) begin
			nxt_wd_state = WD_TIMEOUT;
			nxt_wd_cnt = '0;
		end else begin
			case (wd_state_ff)
				WD_WATCH: begin
					if (kick_edge) begin
						nxt_wd_cnt = '0;
					end else if (cnt_at_kick) begin
						nxt_wd_state = WD_TIMEOUT;
						nxt_wd_cnt = '0;
					end
				end
				WD_TIMEOUT: begin
					// Kicks during the low period are ignored; the period runs out
					if (cnt_at_low) begin
						nxt_wd_state = WD_REPEAT;
						nxt_wd_cnt = '0;
					end
				end
				WD_REPEAT: begin
					if (kick_edge) begin
						nxt_wd_state = WD_WATCH;
						nxt_wd_cnt = '0;
					end else if (cnt_at_repeat) begin
						nxt_wd_state = WD_TIMEOUT;
						nxt_wd_cnt = '0;
					end
				end
				default: begin
					nxt_wd_state = WD_TIMEOUT;
					nxt_wd_cnt = '0;
				end
			endcase
		end
	end

	// Reset behaves like a lockout: the host sees one full timeout pulse
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wd_state_ff <= WD_TIMEOUT;
			wd_cnt_ff <= '0;
			wdo_low_ff <= 1'b1;
		end else begin
			wd_state_ff <= nxt_wd_state;
			wd_cnt_ff <= nxt_wd_cnt;
			wdo_low_ff <= (nxt_wd_state == WD_TIMEOUT);
		end
	end
	// Open drain: data held low, only the enable moves
	assign watchdog_timeout_out_n = 1'b0;
	assign watchdog_timeout_oe = wdo_low_ff;

	// Channel fault filters
	wire logic [NUM_CHANNELS-1:0] chan_on_vec;
	wire logic [NUM_CHANNELS-1:0] fault_drive;
	assign chan_on_vec = {channel4_on, channel3_on, channel2_on, channel1_on};
	// Window thresholds (2% vs 5%) live in the analog comparators feeding output_in_window

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
			channel_fault_filter #(
				.FILTER_T(FILTER_T),
				.HOLD_T(HOLD_T)
			) u_filter (
				.mclk(mclk),
				.rst_b(rst_b),
				.tick(tick_ff),
				.chan_on(chan_on_vec[ch]),
				.in_window(output_in_window[ch]),
				.fault_drive(fault_drive[ch])
			);
		end
	endgenerate

	assign channel1_fault_out_n = 1'b0;
	assign channel2_fault_out_n = 1'b0;
	assign channel3_fault_out_n = 1'b0;
	assign channel4_fault_out_n = 1'b0;
	assign channel1_fault_oe = fault_drive[0];
	assign channel2_fault_oe = fault_drive[1];
	assign channel3_fault_oe = fault_drive[2];
	assign channel4_fault_oe = fault_drive[3];

	// Static configuration, registered so outputs come from flip-flops
	logic [2:0] stage_code_ff;
	logic fcm_ff;
	logic [1:0] osc_ff;
	wire logic nxt_fcm;
	wire logic [1:0] nxt_osc;

	// External clock forces continuous mode; else the level picks the mode
	assign nxt_fcm = ext_clock_present | mode_sync_in;
	assign nxt_osc = ext_clock_present ? OSC_EXTERNAL :
		(frequency_select ? OSC_INTERNAL : OSC_RESISTOR);

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			stage_code_ff <= 3'h0;
			fcm_ff <= 1'b0;
			osc_ff <= OSC_RESISTOR;
		end else begin
			stage_code_ff <= {stage_code_bit2, stage_code_bit1, stage_code_bit0};
			fcm_ff <= nxt_fcm;
			osc_ff <= nxt_osc;
		end
	end
	assign stage_code = stage_code_ff;
	assign forced_continuous = fcm_ff;
	assign osc_source = osc_ff;

	// Lockout yields a low timeout pin on the next edge
	lockout_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
		supply_low_lockout |=> watchdog_timeout_oe) else $error("lockout not asserting");
	// Timeout pin is never driven high
	never_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
		watchdog_timeout_out_n == 1'b0) else $error("timeout pin driven high");
	// A kick in the watch state keeps the pin released
	kick_restart_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wd_state_ff == WD_WATCH && kick_edge && !supply_low_lockout
		|=> wd_cnt_ff == '0 && !watchdog_timeout_oe) else $error("kick did not restart");
	// Low period ends into the repeat wait
	low_to_repeat_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wd_state_ff == WD_TIMEOUT && cnt_at_low && !supply_low_lockout
		|=> wd_state_ff == WD_REPEAT && !watchdog_timeout_oe)
		else $error("timeout low period wrong");
	// Missing kick raises a timeout
	kick_miss_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wd_state_ff == WD_WATCH && cnt_at_kick && !kick_edge && !supply_low_lockout
		|=> watchdog_timeout_oe) else $error("missed kick not reported");
	// Repeat timeout when no kick
	repeat_fire_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wd_state_ff == WD_REPEAT && cnt_at_repeat && !kick_edge && !supply_low_lockout
		|=> watchdog_timeout_oe) else $error("repeat timeout missing");
	// External clock always yields forced continuous mode
	sync_fcm_a: assert property (@(posedge mclk) disable iff (!rst_b)
		ext_clock_present |=> forced_continuous && osc_source == OSC_EXTERNAL)
		else $error("sync mode wrong");
	// Without external clock, frequency select high picks internal oscillator
	osc_select_a: assert property (@(posedge mclk) disable iff (!rst_b)
		!ext_clock_present && frequency_select |=> osc_source == OSC_INTERNAL)
		else $error("oscillator select wrong");
	// Tick stays a one-cycle pulse whenever a tick lasts more than one cycle, so a count never advances twice per tick
	tick_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
		tick_ff && tick_len > 16'h0001 |=> !tick_ff)
		else $error("time base tick longer than one cycle");
	// Kicks during the low period neither end nor restart it
	timeout_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wd_state_ff == WD_TIMEOUT && !cnt_at_low && !supply_low_lockout
		|=> wd_state_ff == WD_TIMEOUT && watchdog_timeout_oe && wd_cnt_ff >= $past(wd_cnt_ff))
		else $error("timeout low period cut short");
	// A kick in the repeat wait returns to watching with the pin released
	repeat_kick_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wd_state_ff == WD_REPEAT && kick_edge && !supply_low_lockout
		|=> wd_state_ff == WD_WATCH && !watchdog_timeout_oe)
		else $error("repeat kick not accepted");
	// Every pin change shows up as an edge two cycles later; only the pin is watched
	kick_latency_a: assert property (@(posedge mclk) disable iff (!rst_b)
		$past(rst_b) && $changed(watchdog_kick_in) |-> ##2 kick_edge)
		else $error("kick edge not detected");
endmodule : watchdog_reset_supervisor

// ==== host_model.sv ====
// Host processor model that keeps the watchdog alive by toggling the kick pin.
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic mclk,
	// Kick control from the bench
	input wire logic kick_en,
	input wire logic [15:0] kick_gap,
	// Kick pin
	output logic watchdog_kick_in
);
	// Cycles since the last toggle; cleared while idle so one enabled cycle gives one kick
	int gap_cnt = 0;
	initial watchdog_kick_in = 1'b0;
	// Toggle on enable and every gap after; both directions count as a kick
	always @(posedge mclk) begin
		if (!kick_en) begin
			gap_cnt <= 0;
		end else begin
			if (gap_cnt == 0) begin
				watchdog_kick_in <= #2 ~watchdog_kick_in;
			end
			gap_cnt <= (gap_cnt + 1 >= int'(kick_gap)) ? 0 : gap_cnt + 1;
		end
	end
endmodule : host_model

// ==== watchdog_reset_supervisor_tb.sv ====
// Self-checking bench for the watchdog and channel fault supervisor.
`timescale 1ns/1ps
module watchdog_reset_supervisor_tb;
	import supervisor_pkg::*;
	// Shortened counts, all in ticks of TB cycles
	localparam int TB = 4;
	localparam int KT = 20;
	localparam int LT = 5;
	localparam int RT = 40;
	localparam int FT = 1;
	localparam int HT = 5;
	// Clock, reset and bench drives
	logic mclk = 1'b0;
	logic rst_b, kick_en, lock, kick, mode, ext, fsel;
	logic [15:0] tbs;
	logic [3:0] on_v, win;
	logic [2:0] sc;
	// Design outputs
	logic wd_n, wd_oe, f1_n, f2_n, f3_n, f4_n, f1_oe, f2_oe, f3_oe, f4_oe, fc;
	logic [2:0] stage_code;
	logic [1:0] osc;
	wire logic [3:0] f_oe = {f4_oe, f3_oe, f2_oe, f1_oe};
	wire logic [4:0] all_oe = {wd_oe, f_oe};
	// Scoreboard
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int n, hi, c, r;
	always #12.5 mclk = ~mclk;
	host_model u_host_model (.mclk(mclk), .kick_en(kick_en), .kick_gap(16'h0028),
		.watchdog_kick_in(kick));
	watchdog_reset_supervisor #(.TICK_CYC(TB), .KICK_T(KT), .LOW_T(LT), .REPEAT_T(RT),
		.FILTER_T(FT), .HOLD_T(HT)) u_watchdog_reset_supervisor (.mclk(mclk), .rst_b(rst_b),
		.timebase_setting(tbs), .watchdog_kick_in(kick), .supply_low_lockout(lock),
		.watchdog_timeout_out_n(wd_n), .watchdog_timeout_oe(wd_oe), .channel1_on(on_v[0]),
		.channel2_on(on_v[1]), .channel3_on(on_v[2]), .channel4_on(on_v[3]),
		.output_in_window(win), .channel1_fault_out_n(f1_n), .channel1_fault_oe(f1_oe),
		.channel2_fault_out_n(f2_n), .channel2_fault_oe(f2_oe), .channel3_fault_out_n(f3_n),
		.channel3_fault_oe(f3_oe), .channel4_fault_out_n(f4_n), .channel4_fault_oe(f4_oe),
		.stage_code_bit0(sc[0]), .stage_code_bit1(sc[1]), .stage_code_bit2(sc[2]),
		.mode_sync_in(mode), .ext_clock_present(ext), .frequency_select(fsel),
		.stage_code(stage_code), .forced_continuous(fc), .osc_source(osc));
	// Verdict, reached from the main sequence or the hang guard
	task automatic complete_run();
		if (num_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	// Compare one value against the model
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask : check
	// Durations jitter by the tick phase and the kick synchronizer
	task automatic near(input int got, input int exp, input int t);
		check((got >= exp - 2 * t - 4 && got <= exp + 2 * t + 4) ? exp : got, exp);
	endtask : near
	// Advance whole cycles, landing just after the edge
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#2;
	endtask : step
	// Count cycles until one open-drain enable reaches a level, bounded
	task automatic wait_bit(input int idx, input logic lvl, output int cnt);
		cnt = 0;
		while (all_oe[idx] !== lvl && cnt < 2000) begin
			step(1);
			cnt++;
		end
	endtask : wait_bit
	// One kick edge at a known time
	task automatic kick_once();
		kick_en = 1'b1;
		step(1);
		kick_en = 1'b0;
	endtask : kick_once
	// Hang guard, far above the expected run of about a thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	// Main sequence
	initial begin
		rst_b = 1'b0;
		kick_en = 1'b0;
		lock = 1'b0;
		tbs = 16'h0004;
		on_v = 4'hF;
		win = 4'hF;
		sc = 3'h0;
		mode = 1'b0;
		ext = 1'b0;
		fsel = 1'b0;
		r = $urandom(32'hA4F7);
		step(6);
		check({all_oe, stage_code, fc, osc}, 32'h7C0);
		rst_b = 1'b1;
		kick_en = 1'b1;
		// Reset behaves as lockout: one full timeout pulse
		wait_bit(4, 1'b0, n);
		near(n, LT * TB, TB);
		step(HT * TB + 8);
		check(f_oe, 4'h0);
		// Steady kicking keeps the pin released
		hi = 0;
		repeat (300) begin
			step(1);
			if (wd_oe !== 1'b0) hi++;
		end
		check(hi, 0);
		// Last kick, then silence
		kick_en = 1'b0;
		step(1);
		kick_once();
		wait_bit(4, 1'b1, n);
		near(n, KT * TB + 3, TB);
		wait_bit(4, 1'b0, n);
		near(n, LT * TB, TB);
		wait_bit(4, 1'b1, n);
		near(n, RT * TB, TB);
		// A kick late in the timeout must not stretch the low period
		step(12);
		kick_once();
		wait_bit(4, 1'b0, n);
		near(n, LT * TB - 13, TB);
		// A kick in the repeat wait restores the short window
		kick_once();
		wait_bit(4, 1'b1, n);
		near(n, KT * TB + 3, TB);
		wait_bit(4, 1'b0, n);
		// Supply lockout forces a full pulse at once
		kick_en = 1'b1;
		lock = 1'b1;
		step(1);
		lock = 1'b0;
		check(wd_oe, 1'b1);
		wait_bit(4, 1'b0, n);
		near(n, LT * TB, TB);
		// Doubling the time base doubles the pulse
		tbs = 16'h0008;
		lock = 1'b1;
		step(1);
		lock = 1'b0;
		wait_bit(4, 1'b0, n);
		near(n, LT * 8, 8);
		tbs = 16'h0004;
		// Per channel: disable, release hold, short dip, filtered dip
		for (c = 0; c < 4; c++) begin
			on_v[c] = 1'b0;
			step(1);
			check(f_oe, 4'h1 << c);
			on_v[c] = 1'b1;
			wait_bit(c, 1'b0, n);
			near(n, HT * TB, TB);
			// A one-cycle dip is a transient and must be filtered out
			win[c] = 1'b0;
			step(1);
			win[c] = 1'b1;
			step(FT * TB + 4);
			check(f_oe, 4'h0);
			win[c] = 1'b0;
			wait_bit(c, 1'b1, n);
			near(n, FT * TB, TB);
			check(n > FT * TB, 1'b1);
			win[c] = 1'b1;
			wait_bit(c, 1'b0, n);
			near(n, HT * TB, TB);
		end
		// Random static configuration
		repeat (8) begin
			r = $urandom;
			{ext, mode, fsel, sc} = r[5:0];
			// Channels 2 and 3 are tied off where the stage code leaves them unused
			on_v[1] = !(sc[2] && sc[1:0] != 2'h0);
			on_v[2] = !(sc == 3'h4 || sc == 3'h7);
			step(2);
			check(stage_code, sc);
			check(f_oe[2:1] | on_v[2:1], 2'h3);
			check(fc, ext | mode);
			check(osc, ext ? OSC_EXTERNAL : (fsel ? OSC_INTERNAL : OSC_RESISTOR));
		end
		// Open-drain data never drives high
		check({wd_n, f4_n, f3_n, f2_n, f1_n}, 5'h00);
		complete_run();
	end
endmodule : watchdog_reset_supervisor_tb
